//--- spp_top.sv
`timescale 1ns/100ps
`include "spp_cfg.svh"
module spp_fifo #(
    parameter int W = `SPP_W,
    parameter int D = `SPP_D
) (
    input  wire logic                     clk_in,
    input  wire logic                     srst_in,
    input  wire logic                     ce_in,
    input  wire logic                     clr_in,
    input  wire logic                     wvalid_in,
    output logic                          wready_out,
    input  wire logic [W-1:0]             wdata_in,
    output logic                          rvalid_out,
    input  wire logic                     rready_in,
    output logic [W-1:0]                  rdata_out,
    output logic [$clog2(D+1)-1:0]        level_out
);
    localparam int AW = $clog2(D);
    localparam int LW = $clog2(D+1);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [LW-1:0] cnt_q;
    logic          push;
    logic          pop;

    assign wready_out = cnt_q != LW'(D);
    assign rvalid_out = cnt_q != '0;
    assign rdata_out  = mem_q[rp_q];
    assign level_out  = cnt_q;
    assign push       = wvalid_in && wready_out;
    assign pop        = rvalid_out && rready_in;

    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem_q[wp_q] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || (ce_in && clr_in)) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            if (push) begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + AW'(1);
            end
            cnt_q <= cnt_q + LW'(push) - LW'(pop);
        end
    end
endmodule

module spp_top (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             ce_in,
    input  wire spp_pkg::spp_req_t bus_in,
    output logic [15:0]           rdata_out,
    output logic                  rvalid_out,
    input  wire logic             simo_in,
    input  wire logic             somi_in,
    input  wire logic             sclk_in,
    input  wire logic             ste_n_in,
    output var spp_pkg::spp_pin_t simo_out,
    output var spp_pkg::spp_pin_t somi_out,
    output var spp_pkg::spp_pin_t sclk_out,
    output var spp_pkg::spp_pin_t ste_n_out,
    output logic                  irq_rx_out,
    output logic                  irq_tx_out
);
    import spp_pkg::*;

    function automatic logic [7:0] spp_period(input logic [6:0] b);
        spp_period = (b >= `SPP_DIV_MIN) ? {1'b0, b} + 8'h01 : `SPP_P_SLOW;
    endfunction

    spp_state_t  st_q;
    logic [7:0]  ccr_q;
    logic [7:0]  ctl_q;
    logic [7:0]  fct_q;
    logic [7:0]  pri_q;
    logic [6:0]  brr_q;
    logic        ffen_q;
    logic        txrn_q;
    logic        rxrn_q;
    logic        ovr_q;
    logic        ovf_q;
    logic        drd_q;
    logic [15:0] txs_q;
    logic [15:0] rxs_q;
    logic [4:0]  scnt_q;
    logic [7:0]  hcnt_q;
    logic        sclk_q;
    logic        sclk_p_q;
    logic        hit_ccr, hit_ctl, hit_sts, hit_brr, hit_emu, hit_rxb;
    logic        hit_txb, hit_dat, hit_ftx, hit_frx, hit_fct, hit_pri;
    logic        wr_lo, wr_w, srun, pol, mst, pha, talk, ie, sel;
    logic        run, tick, lead, trail, samp, shft, done, start, abort;
    logic        din, tx_can, rx_can, rxf;
    logic        tx_wr, tx_rv, rx_wr, rx_rv;
    logic [15:0] tx_rd, rx_rd, rx_word, rd;
    logic [4:0]  tx_lvl, rx_lvl, nbits, scnt_n;
    logic [7:0]  per, half;

    assign hit_ccr = bus_in.addr == `SPP_A_CCR;
    assign hit_ctl = bus_in.addr == `SPP_A_CTL;
    assign hit_sts = bus_in.addr == `SPP_A_STS;
    assign hit_brr = bus_in.addr == `SPP_A_BRR;
    assign hit_emu = bus_in.addr == `SPP_A_EMU;
    assign hit_rxb = bus_in.addr == `SPP_A_RXB;
    assign hit_txb = bus_in.addr == `SPP_A_TXB;
    assign hit_dat = bus_in.addr == `SPP_A_DAT;
    assign hit_ftx = bus_in.addr == `SPP_A_FTX;
    assign hit_frx = bus_in.addr == `SPP_A_FRX;
    assign hit_fct = bus_in.addr == `SPP_A_FCT;
    assign hit_pri = bus_in.addr == `SPP_A_PRI;
    // High byte lane never reaches control registers
    assign wr_lo = bus_in.we && bus_in.be[0]; // R12
    assign wr_w  = bus_in.we && (&bus_in.be);
    assign srun  = ccr_q[`SPP_CCR_RSTN];
    assign pol   = ccr_q[`SPP_CCR_POL];
    assign mst   = ctl_q[`SPP_CTL_MST];
    assign pha   = ctl_q[`SPP_CTL_PHA];
    assign talk  = ctl_q[`SPP_CTL_TALK];
    assign ie    = ctl_q[`SPP_CTL_IE];
    assign sel   = !ste_n_in; // R14
    assign nbits = {1'b0, ccr_q[`SPP_CCR_LEN]} + 5'h01; // R3
    assign per   = spp_period(brr_q); // R1 R2
    // Idle-level half gets the spare cycle of an odd period
    assign half  = (sclk_q == pol) ? per - {1'b0, per[7:1]} : {1'b0, per[7:1]};
    assign run   = st_q == SPP_RUN;
    assign tick  = hcnt_q == half - 8'h01;
    assign lead  = run && (mst ? tick && sclk_q == pol
                               : sel && sclk_p_q == pol && sclk_in != pol); // R4
    assign trail = run && (mst ? tick && sclk_q != pol
                               : sel && sclk_p_q != pol && sclk_in == pol); // R17
    assign samp  = pha ? lead : trail; // R5 R6 R7 R8
    assign shft  = pha ? trail : lead; // R5 R6 R7 R8
    assign scnt_n = scnt_q + 5'(samp);
    assign done  = trail && scnt_n == nbits; // R3
    assign din   = mst ? somi_in : simo_in; // R15
    assign start = !run && srun && (mst ? tx_rv : sel);
    assign abort = run && !mst && !sel; // R17
    assign rx_word = (samp ? {rxs_q[14:0], din} : rxs_q)
                   & (16'hffff >> (4'hf - ccr_q[`SPP_CCR_LEN]));
    // Without the queues each side behaves as a single buffer
    assign tx_can = ffen_q ? tx_wr : tx_lvl == 5'h00; // R13
    assign rx_can = ffen_q ? rx_wr : rx_lvl == 5'h00; // R13
    assign rxf    = rx_rv;

    spp_fifo #(.W(`SPP_W), .D(`SPP_D)) u_txq (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        // Queue reset only bites in queue mode; buffer mode must still run
        .clr_in     (!srun || (ffen_q && !txrn_q)), // R13
        .wvalid_in  (wr_w && hit_txb && tx_can),
        .wready_out (tx_wr),
        .wdata_in   (bus_in.wdata),
        .rvalid_out (tx_rv),
        .rready_in  (start),
        .rdata_out  (tx_rd),
        .level_out  (tx_lvl)
    );

    spp_fifo #(.W(`SPP_W), .D(`SPP_D)) u_rxq (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .clr_in     (!srun || (ffen_q && !rxrn_q)), // R13
        .wvalid_in  (done && rx_can),
        .wready_out (rx_wr),
        .wdata_in   (rx_word),
        .rvalid_out (rx_rv),
        .rready_in  (bus_in.re && hit_rxb),
        .rdata_out  (rx_rd),
        .level_out  (rx_lvl)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ccr_q  <= `SPP_RST8;
            ctl_q  <= `SPP_RST8;
            brr_q  <= `SPP_RST7;
            fct_q  <= `SPP_RST8;
            pri_q  <= `SPP_RST8;
            ffen_q <= 1'b0;
            txrn_q <= 1'b0;
            rxrn_q <= 1'b0;
        end else if (ce_in && wr_lo) begin
            if (hit_ccr) ccr_q <= bus_in.wdata[7:0];
            if (hit_ctl) ctl_q <= bus_in.wdata[7:0];
            if (hit_brr) brr_q <= bus_in.wdata[6:0];
            if (hit_fct) fct_q <= bus_in.wdata[7:0];
            if (hit_pri) pri_q <= bus_in.wdata[7:0];
            if (hit_ftx) begin
                ffen_q <= bus_in.wdata[`SPP_FF_HI];
                txrn_q <= bus_in.wdata[`SPP_FF_RSTN];
            end
            if (hit_frx) rxrn_q <= bus_in.wdata[`SPP_FF_RSTN];
        end
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge clk_in) begin
        if (srst_in || (ce_in && !srun)) begin
            ovr_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (ce_in) begin
            if (done && !rx_can && !ffen_q) begin
                ovr_q <= 1'b1; // R10
            end else if (wr_lo && hit_sts && bus_in.wdata[`SPP_STS_OVR]) begin
                ovr_q <= 1'b0;
            end
            if (done && !rx_can && ffen_q) begin
                ovf_q <= 1'b1; // R10
            end else if (wr_lo && hit_frx && bus_in.wdata[`SPP_FF_HI]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || (ce_in && !srun)) begin
            st_q   <= SPP_IDLE;
            scnt_q <= 5'h00;
            hcnt_q <= 8'h00;
            sclk_q <= 1'b0;
        end else if (ce_in) begin
            unique case (st_q)
                SPP_IDLE: begin
                    sclk_q <= pol;
                    hcnt_q <= 8'h00;
                    scnt_q <= 5'h00;
                    if (start) st_q <= SPP_RUN;
                end
                SPP_RUN: begin
                    if (abort || done) st_q <= SPP_IDLE;
                    hcnt_q <= tick ? 8'h00 : hcnt_q + 8'h01;
                    if (mst && tick) sclk_q <= !sclk_q; // R4
                    if (samp) scnt_q <= scnt_n;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            txs_q    <= `SPP_RST16;
            rxs_q    <= `SPP_RST16;
            sclk_p_q <= 1'b0;
        end else if (ce_in) begin
            sclk_p_q <= sclk_in;
            // Low bits past the character length are never sent
            if (start && tx_rv) begin
                txs_q <= tx_rd; // R16
            end else if (!run && wr_w && hit_dat) begin
                txs_q <= bus_in.wdata;
            end else if (shft && scnt_q != 5'h00 && scnt_q != nbits) begin
                txs_q <= {txs_q[14:0], 1'b0}; // R16
            end
            // Reception runs whether or not transmit is enabled
            if (start) begin
                rxs_q <= `SPP_RST16;
            end else if (samp) begin
                rxs_q <= {rxs_q[14:0], din}; // R9
            end
        end
    end

    always_comb begin
        rd = `SPP_RST16;
        unique case (1'b1)
            hit_ccr: rd[7:0] = ccr_q; // R12
            hit_ctl: rd[7:0] = ctl_q;
            hit_sts: rd[7:0] = {ovr_q, rxf, !tx_can, 5'h00}; // R10
            hit_brr: rd[7:0] = {1'b0, brr_q};
            hit_emu: rd = rx_rd;
            hit_rxb: rd = rx_rd;
            hit_txb: rd = tx_rd;
            hit_dat: rd = rxs_q;
            hit_ftx: rd[7:0] = {ffen_q, txrn_q, 1'b0, tx_lvl};
            hit_frx: rd[7:0] = {ovf_q, rxrn_q, 1'b0, rx_lvl};
            hit_fct: rd[7:0] = fct_q;
            hit_pri: rd[7:0] = pri_q;
            default: rd = `SPP_RST16;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out  <= `SPP_RST16;
            rvalid_out <= 1'b0;
            drd_q      <= 1'b0;
        end else if (ce_in) begin
            rdata_out  <= bus_in.re ? rd : `SPP_RST16;
            rvalid_out <= bus_in.re;
            drd_q      <= hit_emu || hit_rxb || hit_txb || hit_dat;
        end
    end

    // Pins lag the engine by one cycle, clock and data alike
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            simo_out   <= '0;
            somi_out   <= '0;
            sclk_out   <= '0;
            ste_n_out  <= '0;
            irq_rx_out <= 1'b0;
            irq_tx_out <= 1'b0;
        end else if (ce_in) begin
            sclk_out   <= '{d: sclk_q, oe: mst}; // R4
            simo_out   <= '{d: txs_q[15], oe: mst && talk}; // R15 R9
            somi_out   <= '{d: txs_q[15], oe: !mst && talk && sel}; // R17
            ste_n_out  <= '{d: !run, oe: mst};
            irq_rx_out <= ie && (rxf
                          || ((ovr_q || ovf_q) && ctl_q[`SPP_CTL_OVIE])); // R10
            irq_tx_out <= ie && tx_can; // R10
        end
    end

    logic [7:0] pcnt_q;
    logic       pseen_q;
    logic [4:0] lc_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pcnt_q  <= 8'h00;
            pseen_q <= 1'b0;
            lc_q    <= 5'h00;
        end else if (ce_in) begin
            pcnt_q  <= (!run || lead) ? 8'h01 : pcnt_q + 8'h01;
            pseen_q <= run && (pseen_q || lead);
            lc_q    <= start ? 5'h00 : lc_q + 5'(lead);
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in || !ce_in);

    sequence s_mstart;
        mst && start && tx_rv;
    endsequence

    chk_baud_div: assert property ( // R1
        mst && lead && pseen_q && brr_q >= `SPP_DIV_MIN
        |-> pcnt_q == {1'b0, brr_q} + 8'h01)
        else $error("serial clock period wrong");
    chk_baud_slow: assert property ( // R2
        mst && lead && pseen_q && brr_q < `SPP_DIV_MIN
        |-> pcnt_q == `SPP_P_SLOW)
        else $error("slow serial clock period wrong");
    chk_char_len: assert property ( // R3
        done |-> lc_q == nbits)
        else $error("edge count differs from length");
    chk_clk_role: assert property ( // R4
        sclk_out.oe == $past(mst))
        else $error("clock drive does not follow role");
    chk_tx_nodly: assert property ( // R5 R7
        !pha && $past(run) && $changed(txs_q) |-> $past(lead))
        else $error("data moved off leading edge");
    chk_tx_dly: assert property ( // R6 R8
        pha && $past(run) && $changed(txs_q) |-> $past(trail))
        else $error("delayed data moved off trailing edge");
    chk_rx_edge: assert property ( // R5 R6 R7 R8
        $past(run) && $changed(scnt_q) && scnt_q != 5'h00
        |-> ($past(pha) ? $past(lead) : $past(trail)))
        else $error("sample on wrong edge");
    chk_talk_off: assert property ( // R9
        !talk |=> !simo_out.oe && !somi_out.oe)
        else $error("data driven with transmit off");
    chk_rx_irq: assert property ( // R10
        ie && rxf |=> irq_rx_out)
        else $error("receive request missing");
    chk_hi_byte: assert property ( // R12
        rvalid_out && !drd_q |-> rdata_out[15:8] == 8'h00)
        else $error("high byte not zero");
    chk_fifo_cap: assert property ( // R13
        tx_lvl <= 5'(`SPP_D) && rx_lvl <= 5'(`SPP_D))
        else $error("queue level beyond depth");
    chk_pin_dir: assert property ( // R15
        $past(mst) ? !somi_out.oe : !simo_out.oe)
        else $error("data pin direction wrong");
    chk_msb_first: assert property ( // R16
        s_mstart |=> ##1 simo_out.d == $past(tx_rd[15], 2))
        else $error("first bit is not the top bit");
    chk_slave_quiet: assert property ( // R17
        run && !mst && !sel |=> st_q == SPP_IDLE && !somi_out.oe)
        else $error("deselected slave still active");
endmodule

//--- spp_cfg.svh
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// Summary of operation
// R1 - Divisor 3..127: clock is input/(divisor+1)
// R2 - Divisor 0..2: clock is input/4
// R3 - Character length one to sixteen bits
// R4 - Master drives clock, slave accepts it
// R5 - Idle high, no delay: out fall, in rise
// R6 - Idle high, delayed: early out, in fall
// R7 - Idle low, no delay: out rise, in fall
// R8 - Idle low, delayed: early out, in rise
// R9 - Full duplex, transmit can be disabled
// R10 - Flags and interrupt requests for servicing
// R11 - Software uses 16-bit accesses only
// R12 - Low byte data, high byte reads zero
// R13 - Optional 16-entry transmit and receive queues
// R14 - Outside master drives select low
// R15 - Data pin directions follow the role
// R16 - MSB first, transmit data left-justified
// R17 - Deselected slave floats output, ignores clock
`define SPP_A_CCR 16'h7040
`define SPP_A_CTL 16'h7041
`define SPP_A_STS 16'h7042
`define SPP_A_BRR 16'h7044
`define SPP_A_EMU 16'h7046
`define SPP_A_RXB 16'h7047
`define SPP_A_TXB 16'h7048
`define SPP_A_DAT 16'h7049
`define SPP_A_FTX 16'h704a
`define SPP_A_FRX 16'h704b
`define SPP_A_FCT 16'h704c
`define SPP_A_PRI 16'h704f
`define SPP_CCR_RSTN 7
`define SPP_CCR_POL 6
`define SPP_CCR_LEN 3:0
`define SPP_CTL_IE 0
`define SPP_CTL_TALK 1
`define SPP_CTL_MST 2
`define SPP_CTL_PHA 3
`define SPP_CTL_OVIE 4
`define SPP_STS_OVR 7
`define SPP_FF_HI 7
`define SPP_FF_RSTN 6
`define SPP_DIV_MIN 7'h03
`define SPP_P_SLOW 8'h04
`define SPP_W 16
`define SPP_D 16
`define SPP_RST8 8'h00
`define SPP_RST7 7'h00
`define SPP_RST16 16'h0000
`endif

//--- spp_pkg.sv
package spp_pkg;
    typedef enum logic [0:0] {
        SPP_IDLE = 1'b0,
        SPP_RUN  = 1'b1
    } spp_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
        logic        we;
        logic        re;
    } spp_req_t;
    typedef struct packed {
        logic d;
        logic oe;
    } spp_pin_t;
endpackage

//--- spp_peer_model.sv
`timescale 1ns/100ps
module spp_peer_model (
    input  wire logic        sclk_in,
    input  wire logic        sel_n_in,
    input  wire logic        mosi_in,
    input  wire logic        pol_in,
    input  wire logic        pha_in,
    input  wire logic [15:0] tx_in,
    output logic             miso_out,
    output logic [15:0]      rx_out
);
    logic [4:0] sidx;
    logic       lead;
    logic       act;
    int         k;
    initial begin
        miso_out = 1'b0;
        rx_out   = 16'h0000;
        sidx     = 5'h00;
        act      = 1'b0;
    end
    // Released line flips so a stale bit never passes
    always @(posedge sel_n_in) begin
        miso_out = ~miso_out;
        // Late clear keeps a last edge that shares this step
        act <= 1'b0;
    end
    always @(negedge sel_n_in) begin
        act      = 1'b1;
        sidx     = 5'h00;
        rx_out   = 16'h0000;
        miso_out = tx_in[15];
    end
    // Reacts at the pin edge, so even the shortest half period is met
    always @(sclk_in) begin
        if (act) begin
            lead = (sclk_in != pol_in);
            if (lead == pha_in) begin
                rx_out = {rx_out[14:0], mosi_in};
            end else begin
                k = 15 - int'(sidx) - int'(pha_in);
                if (k >= 0) begin
                    miso_out = tx_in[k];
                end
                sidx = sidx + 5'h01;
            end
        end
    end
endmodule

//--- spp_tb_top.sv
`timescale 1ns/100ps
`include "spp_cfg.svh"
module spp_tb_top;
    import spp_pkg::*;
    logic        clk_in   = 1'b0;
    logic        srst_in  = 1'b1;
    spp_req_t    bus_q    = '0;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq_rx;
    logic        irq_tx;
    spp_pin_t    simo_o;
    spp_pin_t    somi_o;
    spp_pin_t    sclk_o;
    spp_pin_t    ste_o;
    logic        tb_sclk  = 1'b0;
    logic        tb_simo  = 1'b0;
    logic        tb_ste_n = 1'b1;
    logic        pol      = 1'b0;
    logic        pha      = 1'b0;
    logic [15:0] ptx      = 16'h36e1;
    logic [15:0] prx;
    logic        p_miso;
    logic        sclk_prev = 1'b0;
    logic        oe_seen   = 1'b0;
    int          per_q     = 0;
    int          per_last  = 0;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          lens[4] = '{16, 8, 2, 5};
    logic [15:0] divs[4] = '{16'h0007, 16'h0002, 16'h0009, 16'h0000};
    logic [15:0] pers[4] = '{16'h0008, 16'h0004, 16'h000a, 16'h0004};
    wire simo_w = simo_o.oe ? simo_o.d : tb_simo;
    wire somi_w = somi_o.oe ? somi_o.d : p_miso;
    wire sclk_w = sclk_o.oe ? sclk_o.d : tb_sclk;
    wire ste_w  = ste_o.oe ? ste_o.d : tb_ste_n;
    wire psel_n = ste_o.oe ? ste_o.d : 1'b1;

    always #4 clk_in = ~clk_in;

    spp_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
        .bus_in(bus_q), .rdata_out(rdata), .rvalid_out(rvalid),
        .simo_in(simo_w), .somi_in(somi_w), .sclk_in(sclk_w),
        .ste_n_in(ste_w), .simo_out(simo_o), .somi_out(somi_o),
        .sclk_out(sclk_o), .ste_n_out(ste_o), .irq_rx_out(irq_rx),
        .irq_tx_out(irq_tx));
    spp_peer_model peer_u (.sclk_in(sclk_w), .sel_n_in(psel_n),
        .mosi_in(simo_w), .pol_in(pol), .pha_in(pha), .tx_in(ptx),
        .miso_out(p_miso), .rx_out(prx));

    // Cycles between rising clock-pin edges; drive seen during a word
    always @(posedge clk_in) begin
        sclk_prev <= sclk_o.d;
        per_q     <= (sclk_o.d && !sclk_prev) ? 1 : per_q + 1;
        if (sclk_o.d && !sclk_prev) begin
            per_last <= per_q;
        end
        if (ste_o.oe && !ste_o.d) begin
            oe_seen <= oe_seen | simo_o.oe;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One-cycle request, always a whole 16-bit word
    task automatic bus(input logic [15:0] a, input logic [15:0] d,
                       input logic w);
        @(posedge clk_in);
        bus_q <= '{addr: a, wdata: d, be: 2'b11, we: w, re: !w};
        @(posedge clk_in);
        bus_q <= '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus(a, d, 1'b1);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        bus(a, 16'h0000, 1'b0);
        #1;
        if (rvalid !== 1'b1) begin
            num_errors++;
            $display("BAD t=%0t no read answer", $time);
            print_verdict();
        end
        d = rdata;
    endtask
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic wait_reg(input logic [15:0] a, input logic [15:0] m,
                            input logic [15:0] v);
        logic [15:0] d;
        for (int n = 0; n < 3000; n++) begin
            rd(a, d);
            if ((d & m) === v) begin
                return;
            end
        end
        num_errors++;
        $display("BAD t=%0t wait ran out", $time);
        print_verdict();
    endtask

    initial begin
        logic [15:0] d;
        int          len;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        rc(`SPP_A_CCR, 16'h0000);
        rc(`SPP_A_CTL, 16'h0000);
        rc(`SPP_A_STS, 16'h0000);
        rc(`SPP_A_FTX, 16'h0000);
        wr(`SPP_A_PRI, 16'hab12);
        rc(`SPP_A_PRI, 16'h0012);
        wr(16'h7043, 16'h00ff);
        rc(16'h7043, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            len = lens[i];
            pol = i[1];
            pha = i[0];
            wr(`SPP_A_CCR, 16'h0080 | (16'(pol) << 6) | 16'(len - 1));
            wr(`SPP_A_CTL, {12'h000, pha, 1'b1, i != 3, 1'b0});
            wr(`SPP_A_BRR, divs[i]);
            oe_seen = 1'b0;
            wr(`SPP_A_TXB, 16'h9c6b);
            wait_reg(`SPP_A_STS, 16'h0040, 16'h0040);
            rc(`SPP_A_RXB, ptx >> (16 - len));
            if (i != 3) begin
                chk(prx & ((16'h0001 << len) - 1),
                    16'h9c6b >> (16 - len));
            end
            chk(16'(per_last), pers[i]);
            chk({15'h0, oe_seen}, {15'h0, i != 3});
            chk({14'h0, sclk_o.d, sclk_o.oe}, {14'h0, pol, 1'b1});
            chk({15'h0, somi_o.oe}, 16'h0000);
            $display("test master mode %0d done", i);
        end
        // Second word lands while the first is unread
        wr(`SPP_A_TXB, 16'h9c6b);
        wr(`SPP_A_TXB, 16'h9c6b);
        wait_reg(`SPP_A_STS, 16'h0080, 16'h0080);
        wr(`SPP_A_STS, 16'h0080);
        rc(`SPP_A_STS, 16'h0040);
        rc(`SPP_A_RXB, ptx >> 11);
        $display("test overrun done");
        // Slow one-bit words let the queue fill before it drains
        pol = 1'b0;
        pha = 1'b0;
        ptx = 16'h8000;
        wr(`SPP_A_CCR, 16'h0080);
        wr(`SPP_A_CTL, 16'h0007);
        wr(`SPP_A_BRR, 16'h007f);
        wr(`SPP_A_FTX, 16'h00c0);
        wr(`SPP_A_FRX, 16'h0040);
        for (int k = 0; k < 18; k++) begin
            wr(`SPP_A_TXB, 16'h8000);
        end
        rc(`SPP_A_FTX, 16'h00d0);
        rc(`SPP_A_STS, 16'h0020);
        chk({15'h0, irq_tx}, 16'h0000);
        wait_reg(`SPP_A_FRX, 16'h0080, 16'h0080);
        rc(`SPP_A_FRX, 16'h00d0);
        chk({15'h0, irq_rx}, 16'h0001);
        for (int k = 0; k < 16; k++) begin
            rc(`SPP_A_RXB, 16'h0001);
        end
        wr(`SPP_A_FRX, 16'h00c0);
        rc(`SPP_A_FRX, 16'h0040);
        chk({14'h0, irq_rx, irq_tx}, 16'h0001);
        $display("test queues done");
        wr(`SPP_A_FTX, 16'h0000);
        wr(`SPP_A_CCR, 16'h0087);
        wr(`SPP_A_CTL, 16'h0002);
        wr(`SPP_A_TXB, 16'ha5ff);
        chk({14'h0, somi_o.oe, sclk_o.oe}, 16'h0000);
        tb_ste_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        d = 16'h0000;
        for (int b = 7; b >= 0; b--) begin
            @(posedge clk_in);
            tb_sclk <= 1'b1;
            tb_simo <= 8'h3c >> b;
            repeat (4) @(posedge clk_in);
            d = {d[14:0], somi_w};
            tb_sclk <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        tb_ste_n <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(d, 16'h00a5);
        chk({15'h0, somi_o.oe}, 16'h0000);
        rc(`SPP_A_EMU, 16'h003c);
        rc(`SPP_A_RXB, 16'h003c);
        $display("test slave done");
        print_verdict();
    end
endmodule
